// ---- hw/scs_clock_ctrl.v ----
// System clock source selection and internal oscillator control, APB slave.
// Assumes one 50 MHz clock; every clock source appears as a one-cycle enable.
// Clock pin and real-time clock inputs are asynchronous and pass the synchronisers.
`include "scs_defs.vh"

module scs_clock_ctrl (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg pready_out,
    output reg [31:0] prdata_out,
    output reg pslverr_out,
    input wire ext_clk_pin_in,
    input wire rtc_osc_in,
    output reg sys_clk_en_out,
    output reg [2:0] sys_clk_src_out,
    output reg osc_power_out,
    output reg osc_clk_gate_out
);
    reg [2:0] clock_source_select_field_q;
    reg [2:0] internal_osc_control_q;
    reg misc_control_q;
    reg [1:0] pin_state_q;
    reg [1:0] pin_state_d;
    reg [2:0] cur_src_q;
    reg [2:0] cur_src_d;
    reg [2:0] req_src;
    reg osc_powered;
    reg osc_out_en;
    wire ext_rise;
    wire ext_fall;
    wire rtc_rise;
    wire tick_div2;
    wire tick_div4;
    wire tick_div8;
    wire setup_phase;
    wire access_done;
    wire wr_en;
    wire int_hold;
    wire pin_ctrl;
    wire power_en;
    wire ext_override;
    wire osc_tick;
    wire cur_tick;
    wire addr_hit;
    wire [1:0] reg_sel;
    wire pin_disabled;
    wire osc_src_gated;
    wire src_switch;
    reg [31:0] rd_word;

    // Register decode results
    localparam REG_NONE = 2'h0;
    localparam REG_CLK_SEL = 2'h1;
    localparam REG_OSC_CTRL = 2'h2;
    localparam REG_MISC_CTRL = 2'h3;

    // Pin control states
    localparam PIN_IDLE = 2'h0;
    localparam PIN_RUN = 2'h1;
    localparam PIN_STOP = 2'h2;

    // Enable pulse of a source code
    function src_tick;
        input [2:0] code;
        input t1;
        input t2;
        input t4;
        input t8;
        input text;
        input trtc;
        begin
            case (code)
                `SCS_SRC_OSC_DIV1: src_tick = t1;
                `SCS_SRC_OSC_DIV2: src_tick = t2;
                `SCS_SRC_OSC_DIV4: src_tick = t4;
                `SCS_SRC_OSC_DIV8: src_tick = t8;
                `SCS_SRC_EXT_CMOS: src_tick = text;
                `SCS_SRC_RTC_OSC: src_tick = trtc;
                default: src_tick = 1'b0;
            endcase
        end
    endfunction

    // True for the oscillator-derived codes
    function is_osc_src;
        input [2:0] code;
        begin
            is_osc_src = (code[2] == 1'b0);
        end
    endfunction

    // Register addressed by a byte address
    function [1:0] reg_index;
        input [7:0] addr;
        begin
            case (addr)
                `SCS_ADDR_CLK_SEL: reg_index = REG_CLK_SEL;
                `SCS_ADDR_OSC_CTRL: reg_index = REG_OSC_CTRL;
                `SCS_ADDR_MISC_CTRL: reg_index = REG_MISC_CTRL;
                default: reg_index = REG_NONE;
            endcase
        end
    endfunction

    // Pin synchronisers and oscillator divider
    scs_sync3 u_ext_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(ext_clk_pin_in),
        .level_out(),
        .rise_out(ext_rise),
        .fall_out(ext_fall)
    );

    scs_sync3 u_rtc_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(rtc_osc_in),
        .level_out(),
        .rise_out(rtc_rise),
        .fall_out()
    );

    scs_osc_div u_osc_div (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .osc_tick_in(osc_tick),
        .tick_div2_out(tick_div2),
        .tick_div4_out(tick_div4),
        .tick_div8_out(tick_div8)
    );

    // APB decode
    assign setup_phase = psel_in && !penable_in;
    assign access_done = psel_in && penable_in && pready_out;
    assign wr_en = access_done && pwrite_in && !pslverr_out;
    assign addr_hit = (reg_index(paddr_in) != REG_NONE);
    assign reg_sel = reg_index(paddr_in);

    // Field views of the registers
    assign int_hold = internal_osc_control_q[`SCS_OSC_INT_HOLD];
    assign pin_ctrl = internal_osc_control_q[`SCS_OSC_PIN_CTRL];
    assign power_en = internal_osc_control_q[`SCS_OSC_POWER_EN];
    assign ext_override = misc_control_q;

    // Read data, upper bits and reserved bit 3 read as zero
    always @* begin
        rd_word = 32'h0;
        case (reg_sel)
            REG_CLK_SEL: begin
                rd_word = {29'h0, clock_source_select_field_q};
            end
            REG_OSC_CTRL: begin
                rd_word = {29'h0, internal_osc_control_q};
            end
            REG_MISC_CTRL: begin
                rd_word[`SCS_MISC_EXT_OVR] = misc_control_q;
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    // Access cycle follows each setup cycle at once, no wait states
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
        end else begin
            pready_out <= setup_phase;
        end
    end

    // Read data and error are taken in the setup cycle
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
        end else if (setup_phase) begin
            prdata_out <= pwrite_in ? 32'h0 : rd_word;
            pslverr_out <= !addr_hit;
        end else if (access_done) begin
            pslverr_out <= 1'b0;
        end
    end

    // Register writes
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            clock_source_select_field_q <= `SCS_RST_CLK_SEL;
            internal_osc_control_q <= `SCS_RST_OSC_CTRL;
            misc_control_q <= `SCS_RST_MISC_CTRL;
        end else if (wr_en) begin
            case (reg_sel)
                REG_CLK_SEL: begin
                    clock_source_select_field_q <= pwdata_in[2:0];
                end
                REG_OSC_CTRL: begin
                    // Bit 3 and above are dropped, a zero write powers down
                    internal_osc_control_q <= pwdata_in[2:0];
                end
                REG_MISC_CTRL: begin
                    misc_control_q <= pwdata_in[`SCS_MISC_EXT_OVR];
                end
                default: begin
                    misc_control_q <= misc_control_q;
                end
            endcase
        end
    end

    // Pin control state, clock pin edges count only in pin mode with hold clear
    always @* begin
        pin_state_d = pin_state_q;
        if (!pin_ctrl || int_hold) begin
            // Hold set first, then cleared, hands over with the oscillator on
            pin_state_d = PIN_IDLE;
        end else begin
            case (pin_state_q)
                PIN_IDLE: begin
                    pin_state_d = ext_rise ? PIN_STOP : PIN_RUN;
                end
                PIN_RUN: begin
                    if (ext_rise) begin
                        pin_state_d = PIN_STOP;
                    end
                end
                PIN_STOP: begin
                    if (ext_fall) begin
                        pin_state_d = PIN_RUN;
                    end
                end
                default: begin
                    pin_state_d = PIN_IDLE;
                end
            endcase
        end
    end

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pin_state_q <= PIN_IDLE;
        end else begin
            pin_state_q <= pin_state_d;
        end
    end

    assign pin_disabled = (pin_state_q == PIN_STOP);

    // Oscillator power and output gate
    always @* begin
        osc_powered = power_en;
        if (pin_ctrl && !int_hold && pin_disabled) begin
            osc_powered = 1'b0;
        end
        // Clearing hold outside pin mode gates the output only, power stays
        osc_out_en = osc_powered && (int_hold || pin_ctrl);
    end

    assign osc_tick = osc_out_en;
    assign osc_src_gated = is_osc_src(cur_src_q) && !osc_out_en;

    // Requested source, reserved codes keep the running source
    always @* begin
        req_src = cur_src_q;
        if (ext_override) begin
            req_src = `SCS_SRC_EXT_CMOS;
        end else begin
            case (clock_source_select_field_q)
                `SCS_SRC_OSC_DIV1,
                `SCS_SRC_OSC_DIV2,
                `SCS_SRC_OSC_DIV4,
                `SCS_SRC_OSC_DIV8: begin
                    req_src = clock_source_select_field_q;
                end
                `SCS_SRC_EXT_CMOS,
                `SCS_SRC_RTC_OSC: begin
                    req_src = clock_source_select_field_q;
                end
                default: begin
                    req_src = cur_src_q;
                end
            endcase
        end
    end

    // Enable pulse of the running source
    assign cur_tick = src_tick(cur_src_q, osc_tick, tick_div2, tick_div4, tick_div8,
                               ext_rise, rtc_rise);

    // Change over only at the end of a whole period of the old source
    always @* begin
        cur_src_d = cur_src_q;
        if (req_src != cur_src_q) begin
            if (cur_tick) begin
                cur_src_d = req_src;
            end else if (osc_src_gated) begin
                // A gated oscillator gives no tick, so nothing is cut short
                cur_src_d = req_src;
            end
        end
    end

    assign src_switch = (cur_src_d != cur_src_q);

    // Source in use and its enable pulse
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cur_src_q <= `SCS_SRC_OSC_DIV1;
            sys_clk_en_out <= 1'b0;
            sys_clk_src_out <= `SCS_SRC_OSC_DIV1;
        end else begin
            cur_src_q <= cur_src_d;
            // Only whole periods of the running source reach the system clock
            sys_clk_en_out <= !src_switch && cur_tick;
            sys_clk_src_out <= cur_src_d;
        end
    end

    // Oscillator power and gate registers
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            osc_power_out <= 1'b1;
            osc_clk_gate_out <= 1'b1;
        end else begin
            osc_power_out <= osc_powered;
            osc_clk_gate_out <= osc_out_en;
        end
    end
endmodule

// ---- hw/scs_defs.vh ----
// Constants for the system clock select and internal oscillator control block.
// Assumes inclusion by bare name from the top design file of the block and the bench files.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Register indices, byte address is four times the index
`define SCS_IDX_CLK_SEL 8'h32
`define SCS_IDX_OSC_CTRL 8'h33
`define SCS_IDX_MISC_CTRL 8'h35
`define SCS_ADDR_CLK_SEL 8'hC8
`define SCS_ADDR_OSC_CTRL 8'hCC
`define SCS_ADDR_MISC_CTRL 8'hD4

// Reset values
`define SCS_RST_CLK_SEL 3'h0
`define SCS_RST_OSC_CTRL 3'h6
`define SCS_RST_MISC_CTRL 1'h0

// Oscillator control field positions
`define SCS_OSC_PIN_CTRL 0
`define SCS_OSC_POWER_EN 1
`define SCS_OSC_INT_HOLD 2

// Misc control field position
`define SCS_MISC_EXT_OVR 2

// Source select codes
`define SCS_SRC_OSC_DIV1 3'h0
`define SCS_SRC_OSC_DIV2 3'h1
`define SCS_SRC_OSC_DIV4 3'h2
`define SCS_SRC_OSC_DIV8 3'h3
`define SCS_SRC_EXT_CMOS 3'h4
`define SCS_SRC_RTC_OSC 3'h5

`endif

// ---- hw/scs_sync3.v ----
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input level and a single system clock.
module scs_sync3 (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire async_in,
    output reg level_out,
    output wire rise_out,
    output wire fall_out
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Accept a change once stages two and three agree
            if (s2_q == s3_q) begin
                level_out <= s3_q;
            end
        end
    end

    assign rise_out = (s2_q == s3_q) && s3_q && !level_out;
    assign fall_out = (s2_q == s3_q) && !s3_q && level_out;
endmodule

// ---- hw/scs_osc_div.v ----
// Divider of the internal oscillator into one-cycle enable pulses.
// Assumes the oscillator tick is a one-cycle enable on the system clock.
module scs_osc_div (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire osc_tick_in,
    output wire tick_div2_out,
    output wire tick_div4_out,
    output wire tick_div8_out
);
    reg [2:0] cnt_q;

    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 3'h0;
        end else if (osc_tick_in) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign tick_div2_out = osc_tick_in && cnt_q[0];
    assign tick_div4_out = osc_tick_in && (cnt_q[1:0] == 2'h3);
    assign tick_div8_out = osc_tick_in && (cnt_q == 3'h7);
endmodule

// ---- bench/scs_pin_src.sv ----
// Pin clock model for the external clock and real-time clock inputs.
// Assumes the system clock paces it; stopped, the pin stands at lvl_in.
module scs_pin_src (
    input wire ref_clk_in,
    input wire run_in,
    input wire lvl_in,
    input wire [7:0] half_in,
    output logic pin_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q = 8'h00;
    always @(posedge ref_clk_in) begin
        if (!run_in) begin
            cnt_q <= 8'h00;
            pin_out <= lvl_in;
        end else if (cnt_q == half_in) begin
            cnt_q <= 8'h00;
            pin_out <= ~pin_out;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// ---- bench/scs_clock_ctrl_chk.sv ----
// Port checker of the clock select block.
// Assumes a bind to scs_clock_ctrl, one clock, synchronous reset.
`include "scs_defs.vh"
module scs_clock_ctrl_chk (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire [31:0] prdata_out,
    input wire pslverr_out,
    input wire ext_clk_pin_in,
    input wire rtc_osc_in,
    input wire sys_clk_en_out,
    input wire [2:0] sys_clk_src_out,
    input wire osc_power_out,
    input wire osc_clk_gate_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire [2:0] src = sys_clk_src_out;
    wire en = sys_clk_en_out;
    reset_state_a: assert property ($rose(rst_n_in) |->
        src == 3'h0 && osc_power_out && osc_clk_gate_out) else $error("bad reset state");
    div_two_a: assert property (src == 3'h1 && en |=> !en) else $error("div2 early");
    div_four_a: assert property (src == 3'h2 && en |=>
        (src != 3'h2 || !en) [*3]) else $error("div4 early");
    div_eight_a: assert property (src == 3'h3 && en |=>
        (src != 3'h3 || !en) [*7]) else $error("div8 early");
    src_code_a: assert property (src <= 3'h5) else $error("reserved source");
    gated_osc_a: assert property (!osc_clk_gate_out && !$past(osc_clk_gate_out)
        && src < 3'h4 |-> !en) else $error("pulse while gated");
    gate_power_a: assert property (osc_clk_gate_out |-> osc_power_out)
        else $error("gate open unpowered");
    power_off_a: assert property (psel_in && penable_in && pready_out && pwrite_in
        && paddr_in == `SCS_ADDR_OSC_CTRL && !pwdata_in[1] |-> ##2 !osc_power_out)
        else $error("power stays on");
    read_sel_a: assert property (pready_out && !pwrite_in
        && paddr_in == `SCS_ADDR_CLK_SEL |-> prdata_out[31:3] == 29'h0)
        else $error("select upper bits");
    read_osc_a: assert property (pready_out && !pwrite_in
        && paddr_in == `SCS_ADDR_OSC_CTRL |-> prdata_out[31:3] == 29'h0)
        else $error("osc upper bits");
endmodule
bind scs_clock_ctrl scs_clock_ctrl_chk scs_clock_ctrl_chk_i (.*);

// ---- bench/scs_clock_ctrl_tb.sv ----
// Testbench of the clock select block, driven over APB.
// Assumes the design files and scs_defs.vh are compiled first.
`include "scs_defs.vh"
module scs_clock_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic pready_out, pslverr_out, sys_clk_en_out, osc_power_out, osc_clk_gate_out;
    logic [31:0] prdata_out, rdat;
    logic [2:0] sys_clk_src_out;
    logic ext_clk_pin_in, rtc_osc_in, serr;
    logic e_run = 1'b0, e_lvl = 1'b0, r_run = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    int pulses;
    always #10 ref_clk_in = ~ref_clk_in;
    scs_clock_ctrl scs_clock_ctrl_i (.*);
    scs_pin_src ext_src_i (.ref_clk_in(ref_clk_in), .run_in(e_run), .lvl_in(e_lvl),
        .half_in(8'h04), .pin_out(ext_clk_pin_in));
    scs_pin_src rtc_src_i (.ref_clk_in(ref_clk_in), .run_in(r_run), .lvl_in(1'b0),
        .half_in(8'h03), .pin_out(rtc_osc_in));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        @(posedge ref_clk_in);
        while (pready_out !== 1'b1) @(posedge ref_clk_in);
        rdat = prdata_out;
        serr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask
    task count(input int n);
        pulses = 0;
        repeat (n) begin
            @(negedge ref_clk_in);
            pulses += (sys_clk_en_out === 1'b1);
        end
    endtask
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, `SCS_ADDR_CLK_SEL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, `SCS_ADDR_OSC_CTRL, 32'h0);
        chk(rdat, 32'h6);
        apb(1'b0, `SCS_ADDR_MISC_CTRL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(serr, 1'b1);
        chk(rdat, 32'h0);
        apb(1'b1, `SCS_ADDR_CLK_SEL, 32'hFFFFFFF8);
        apb(1'b0, `SCS_ADDR_CLK_SEL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, `SCS_ADDR_OSC_CTRL, 32'hFFFFFFF7);
        apb(1'b0, `SCS_ADDR_OSC_CTRL, 32'h0);
        chk(rdat, 32'h7);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `SCS_ADDR_CLK_SEL, k);
            cyc(12);
            chk(sys_clk_src_out, k);
            count(64);
            chk(pulses, 32'h40 >> k);
        end
        apb(1'b1, `SCS_ADDR_CLK_SEL, 32'h6);
        cyc(12);
        chk(sys_clk_src_out, 3'h3);
        apb(1'b1, `SCS_ADDR_CLK_SEL, 32'h4);
        e_run <= 1'b1;
        r_run <= 1'b1;
        cyc(40);
        chk(sys_clk_src_out, 3'h4);
        count(100);
        chk(pulses, 32'hA);
        apb(1'b1, `SCS_ADDR_CLK_SEL, 32'h5);
        cyc(40);
        chk(sys_clk_src_out, 3'h5);
        count(96);
        chk(pulses, 32'hC);
        apb(1'b1, `SCS_ADDR_MISC_CTRL, 32'h4);
        cyc(40);
        chk(sys_clk_src_out, 3'h4);
        count(100);
        chk(pulses, 32'hA);
        apb(1'b1, `SCS_ADDR_MISC_CTRL, 32'h0);
        apb(1'b1, `SCS_ADDR_CLK_SEL, 32'h0);
        cyc(40);
        chk(sys_clk_src_out, 3'h0);
        apb(1'b1, `SCS_ADDR_OSC_CTRL, 32'h2);
        cyc(4);
        chk({osc_power_out, osc_clk_gate_out}, 2'b10);
        count(16);
        chk(pulses, 32'h0);
        apb(1'b1, `SCS_ADDR_OSC_CTRL, 32'h7);
        e_run <= 1'b0;
        apb(1'b1, `SCS_ADDR_OSC_CTRL, 32'h3);
        cyc(4);
        chk({osc_power_out, osc_clk_gate_out}, 2'b11);
        @(posedge ref_clk_in);
        e_lvl <= 1'b1;
        cyc(8);
        chk(osc_power_out, 1'b0);
        @(posedge ref_clk_in);
        e_lvl <= 1'b0;
        cyc(8);
        chk(osc_power_out, 1'b1);
        apb(1'b1, `SCS_ADDR_MISC_CTRL, 32'h4);
        apb(1'b1, `SCS_ADDR_OSC_CTRL, 32'h0);
        cyc(4);
        chk({osc_power_out, osc_clk_gate_out}, 2'b00);
        results();
    end
endmodule
